/* File: rtl/fws_pkg.sv */
// Package of constants for the flash write operation sequencer
// Behaviour
// - Host issues commands from RAM or external memory
// - Host writes registers only register-indirect
// - Register writes are sixteen bits wide
// - Select, load address and data, then start
// - Clearing select before start cancels operation
// - Word program writes 32 bits from data0
// - Double word select 0x1000, start 0x8000
// - Double word ignores address bit two
// - Erase clears sectors set in erase select
// - Writing 0x4000 suspends running operation
// - Resume sets erase select then start
// - Completed erase reads erase select as zero
// - Changed select bits on resume abort, flag error
// - Suspended erase allows program of another sector
// - Program in suspend clears suspend and erase select
// - Program during erase suspend cannot be suspended
// - Never start while suspend bit set
// - Set protection programs bits to zero
// - Permanent disable: write 0xFFFE to data0 low
// - Permanent re-enable: write 0xFFFE to data0 high
// - Disable and re-enable cycle at most 16 times
// - Temporary unprotect set only from internal flash
// - Access protection gates register writes, but nothing sets it
package fws_pkg;
   // Register selects on the internal bus
   localparam logic [3:0] FWS_A_CW0L = 4'h0;
   localparam logic [3:0] FWS_A_CW0H = 4'h1;
   localparam logic [3:0] FWS_A_ES_L = 4'h2;
   localparam logic [3:0] FWS_A_ES_H = 4'h3;
   localparam logic [3:0] FWS_A_TA_L = 4'h4;
   localparam logic [3:0] FWS_A_TA_H = 4'h5;
   localparam logic [3:0] FWS_A_D0_L = 4'h6;
   localparam logic [3:0] FWS_A_D0_H = 4'h7;
   localparam logic [3:0] FWS_A_D1_L = 4'h8;
   localparam logic [3:0] FWS_A_D1_H = 4'h9;
   localparam logic [3:0] FWS_A_ERR = 4'hA;
   localparam logic [3:0] FWS_A_TAU = 4'hB;
   localparam logic [3:0] FWS_A_STAT = 4'hC;
   // Control word zero high bits and values, error flag and address bit
   localparam int FWS_B_START = 15;
   localparam int FWS_B_SUSPEND_REQUEST = 14;
   localparam int FWS_B_WPG = 13;
   localparam int FWS_B_DOUBLE_WORD_PROGRAM_SELECT = 12;
   localparam int FWS_B_SER = 11;
   localparam int FWS_B_SPR = 8;
   localparam int FWS_B_RESUME_ERROR_FLAG = 0;
   localparam int FWS_B_ADDRESS_BIT_TWO = 2;
   localparam logic [15:0] FWS_SEL_MASK = 16'h3900;
   localparam logic [15:0] FWS_V_DOUBLE_WORD_PROGRAM_SELECT = 16'h1000;
   localparam logic [15:0] FWS_V_START = 16'h8000;
   localparam logic [15:0] FWS_V_SUSPEND_REQUEST = 16'h4000;
   localparam logic [15:0] FWS_V_SER = 16'h0800;
   localparam logic [15:0] FWS_V_SPR = 16'h0100;
   localparam logic [15:0] FWS_V_ZERO = 16'h0000;
   localparam logic [15:0] FWS_V_ONES = 16'hFFFF;
   // Protection register address, data and re-enable limit
   localparam logic [15:0] FWS_PROT_ADDR = 16'hDFBC;
   localparam logic [15:0] FWS_PROT_CLR0 = 16'hFFFE;
   localparam logic [4:0] FWS_PROT_MAX = 5'h10;
   // Array busy time per operation, cycles
   localparam logic [7:0] FWS_PROG_CYC = 8'h20;
   localparam logic [7:0] FWS_ERASE_CYC = 8'h80;
   localparam logic [7:0] FWS_PROT_CYC = 8'h20;
   typedef enum logic [2:0] {
      FWS_OP_NONE, FWS_OP_WORD, FWS_OP_DWORD, FWS_OP_ERASE, FWS_OP_PROT
   } fws_op_t;
endpackage : fws_pkg

/* File: rtl/fws_if.sv */
// Internal bus interface between CPU side and flash sequencer
`timescale 1ns/100ps
`default_nettype none
interface fws_if;
   logic [3:0] addr;
   logic [15:0] wdata;
   logic wr;
   logic rd;
   logic from_flash;
   logic [15:0] rdata;
   modport dev (input addr, wdata, wr, rd, from_flash, output rdata);
   modport host (output addr, wdata, wr, rd, from_flash, input rdata);
endinterface : fws_if
`default_nettype wire

/* File: rtl/fws_host.sv */
// CPU side: turns software port requests into internal bus words
`timescale 1ns/100ps
`default_nettype none
module fws_host
   import fws_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Software port
   input wire logic [3:0] sw_addr,
   input wire logic [15:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   input wire logic sw_from_flash,
   output logic [15:0] sw_rdata,
   // Internal bus
   fws_if.host bus
);
   // Every write is a single 16-bit word through a held address
   logic [3:0] addr_reg;
   logic [15:0] wdata_reg;
   logic wr_reg;
   logic rd_reg;
   logic ff_reg;
   // Code fetch origin is carried so the device can judge
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         addr_reg <= 4'h0;
         wdata_reg <= 16'h0000;
         wr_reg <= 1'b0;
         rd_reg <= 1'b0;
         ff_reg <= 1'b0;
      end
      else
      begin
         addr_reg <= sw_addr;
         wdata_reg <= sw_wdata;
         wr_reg <= sw_wr;
         rd_reg <= sw_rd;
         ff_reg <= sw_from_flash;
      end
   end
   assign bus.addr = addr_reg;
   assign bus.wdata = wdata_reg;
   assign bus.wr = wr_reg;
   assign bus.rd = rd_reg;
   assign bus.from_flash = ff_reg;
   // Device answers one cycle after the bus read; passed straight through
   assign sw_rdata = bus.rdata;
endmodule : fws_host
`default_nettype wire

/* File: rtl/fws_dev.sv */
// Flash write operation sequencer, device end
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module fws_dev
   import fws_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Internal bus
   fws_if.dev bus,
   // Array operation towards the flash core
   output logic arr_busy,
   output logic arr_done,
   output logic [2:0] arr_op,
   output logic [31:0] arr_addr,
   output logic [63:0] arr_data,
   output logic [31:0] arr_sectors,
   // Protection state
   output logic access_protected,
   output logic [15:0] nv_access_protect_low,
   output logic [15:0] nv_access_protect_high
);
   typedef enum logic [1:0] {FWS_IDLE, FWS_RUN, FWS_SUSPEND_REQUEST} fws_state_t;
   fws_state_t st_reg;
   logic [15:0] control_word0_high;
   logic [15:0] control_word0_low;
   logic [15:0] erase_sector_select_low;
   logic [15:0] erase_sector_select_high;
   logic [15:0] target_address_low;
   logic [15:0] target_address_high;
   logic [15:0] data0_low, data0_high, data1_low, data1_high;
   logic [15:0] error_register;
   logic temp_unprotect_bit;
   logic accp_reg;
   logic [4:0] prot_cnt_reg;
   logic [7:0] busy_cnt_reg;
   logic [7:0] saved_cnt_reg;
   fws_op_t op_reg;
   fws_op_t saved_op_reg;
   logic saved_erase_reg;
   logic [15:0] saved_sel_reg;
   logic [15:0] rdata_reg;
   logic wr_ok;
   logic cw_wr;
   logic start_req;
   logic word_program_select, double_word_program_select;
   logic erase_select, set_protection_select, suspend_request;
   fws_op_t sel_op;
   logic finish;

   // Access protection shuts out register writes but TAU; accp_reg is reset low and never set
   assign access_protected = accp_reg && !temp_unprotect_bit;
   assign wr_ok = bus.wr && !access_protected;
   assign cw_wr = wr_ok && bus.addr == FWS_A_CW0H;
   assign word_program_select = control_word0_high[FWS_B_WPG];
   assign double_word_program_select = control_word0_high[FWS_B_DOUBLE_WORD_PROGRAM_SELECT];
   assign erase_select = control_word0_high[FWS_B_SER];
   assign set_protection_select = control_word0_high[FWS_B_SPR];
   assign suspend_request = control_word0_high[FWS_B_SUSPEND_REQUEST];
   assign start_req = cw_wr && bus.wdata[FWS_B_START];
   assign finish = st_reg == FWS_RUN && busy_cnt_reg == 8'h00;

   always_comb
   begin
      sel_op = FWS_OP_NONE;
      if (double_word_program_select)
         sel_op = FWS_OP_DWORD;
      else if (word_program_select)
         sel_op = FWS_OP_WORD;
      else if (erase_select)
         sel_op = FWS_OP_ERASE;
      else if (set_protection_select)
         sel_op = FWS_OP_PROT;
   end

   // Data and address registers; 16-bit words only
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         control_word0_low <= FWS_V_ZERO;
         target_address_low <= FWS_V_ZERO;
         target_address_high <= FWS_V_ZERO;
         data0_low <= FWS_V_ZERO;
         data0_high <= FWS_V_ZERO;
         data1_low <= FWS_V_ZERO;
         data1_high <= FWS_V_ZERO;
      end
      else if (wr_ok)
      begin
         unique case (bus.addr)
            FWS_A_CW0L: control_word0_low <= bus.wdata;
            FWS_A_TA_L: target_address_low <= bus.wdata;
            FWS_A_TA_H: target_address_high <= bus.wdata;
            FWS_A_D0_L: data0_low <= bus.wdata;
            FWS_A_D0_H: data0_high <= bus.wdata;
            FWS_A_D1_L: data1_low <= bus.wdata;
            FWS_A_D1_H: data1_high <= bus.wdata;
            default: ;
         endcase
      end
   end

   // Erase sector selection; cleared when the erase completes
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         erase_sector_select_low <= FWS_V_ZERO;
         erase_sector_select_high <= FWS_V_ZERO;
      end
      else if (finish && op_reg == FWS_OP_ERASE)
      begin
         erase_sector_select_low <= FWS_V_ZERO;
         erase_sector_select_high <= FWS_V_ZERO;
      end
      else if (wr_ok && bus.addr == FWS_A_ES_L)
         erase_sector_select_low <= bus.wdata;
      else if (wr_ok && bus.addr == FWS_A_ES_H)
         erase_sector_select_high <= bus.wdata;
   end

   // Control word zero high; start bit stays high while running
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         control_word0_high <= FWS_V_ZERO;
      else if (finish)
         control_word0_high <= saved_erase_reg ? FWS_V_SUSPEND_REQUEST : FWS_V_ZERO;
      else if (st_reg == FWS_RUN)
      begin
         // Start ignored, only suspend accepted while running
         if (cw_wr && bus.wdata[FWS_B_SUSPEND_REQUEST] && !saved_erase_reg)
            control_word0_high <= control_word0_high | FWS_V_SUSPEND_REQUEST;
      end
      else if (cw_wr)
      begin
         if (st_reg == FWS_SUSPEND_REQUEST && bus.wdata[FWS_B_START] && bus.wdata[FWS_B_SUSPEND_REQUEST])
            control_word0_high <= bus.wdata & ~FWS_V_START;
         else
            control_word0_high <= bus.wdata;
      end
   end

   // Operation sequencing state
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         st_reg <= FWS_IDLE;
         op_reg <= FWS_OP_NONE;
         saved_op_reg <= FWS_OP_NONE;
         saved_sel_reg <= FWS_V_ZERO;
         saved_erase_reg <= 1'b0;
         busy_cnt_reg <= 8'h00;
         saved_cnt_reg <= 8'h00;
      end
      else
      begin
         unique case (st_reg)
            FWS_IDLE:
               // Cancelled selection has no op, so nothing starts
               if (start_req && !bus.wdata[FWS_B_SUSPEND_REQUEST] && sel_op != FWS_OP_NONE)
               begin
                  st_reg <= FWS_RUN;
                  op_reg <= sel_op;
                  saved_sel_reg <= control_word0_high & FWS_SEL_MASK;
                  busy_cnt_reg <= sel_op == FWS_OP_ERASE ? FWS_ERASE_CYC :
                     (sel_op == FWS_OP_PROT ? FWS_PROT_CYC : FWS_PROG_CYC);
               end
            FWS_RUN:
               if (finish)
               begin
                  st_reg <= saved_erase_reg ? FWS_SUSPEND_REQUEST : FWS_IDLE;
                  op_reg <= saved_erase_reg ? saved_op_reg : FWS_OP_NONE;
                  saved_erase_reg <= 1'b0;
                  saved_sel_reg <= saved_erase_reg ? FWS_V_SER : FWS_V_ZERO;
                  // Erase left off where it was suspended, not from zero
                  busy_cnt_reg <= saved_erase_reg ? saved_cnt_reg : 8'h00;
               end
               else if (cw_wr && bus.wdata[FWS_B_SUSPEND_REQUEST] && !saved_erase_reg)
               begin
                  st_reg <= FWS_SUSPEND_REQUEST;
                  saved_op_reg <= op_reg;
               end
               else
                  busy_cnt_reg <= busy_cnt_reg - 8'h01;
            FWS_SUSPEND_REQUEST:
               if (start_req && !bus.wdata[FWS_B_SUSPEND_REQUEST])
               begin
                  if ((bus.wdata & FWS_SEL_MASK) == saved_sel_reg)
                     st_reg <= FWS_RUN;
                  else if (saved_op_reg == FWS_OP_ERASE && !bus.wdata[FWS_B_SER] &&
                     (bus.wdata[FWS_B_WPG] || bus.wdata[FWS_B_DOUBLE_WORD_PROGRAM_SELECT]))
                  begin
                     st_reg <= FWS_RUN;
                     saved_erase_reg <= 1'b1;
                     op_reg <= bus.wdata[FWS_B_DOUBLE_WORD_PROGRAM_SELECT] ? FWS_OP_DWORD : FWS_OP_WORD;
                     saved_cnt_reg <= busy_cnt_reg;
                     busy_cnt_reg <= FWS_PROG_CYC;
                  end
                  else
                  begin
                     st_reg <= FWS_IDLE;
                     op_reg <= FWS_OP_NONE;
                  end
               end
            default: st_reg <= FWS_IDLE;
         endcase
      end
   end

   // Resume error flag: set wins, software clears by writing zero
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         error_register <= FWS_V_ZERO;
      else if (st_reg == FWS_SUSPEND_REQUEST && start_req && !bus.wdata[FWS_B_SUSPEND_REQUEST] &&
         (bus.wdata & FWS_SEL_MASK) != saved_sel_reg &&
         !(saved_op_reg == FWS_OP_ERASE && !bus.wdata[FWS_B_SER] &&
         (bus.wdata[FWS_B_WPG] || bus.wdata[FWS_B_DOUBLE_WORD_PROGRAM_SELECT])))
         error_register[FWS_B_RESUME_ERROR_FLAG] <= 1'b1;
      else if (wr_ok && bus.addr == FWS_A_ERR)
         error_register <= bus.wdata;
   end

   // Temporary unprotect: set only from internal flash fetch
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         temp_unprotect_bit <= 1'b0;
      else if (bus.wr && bus.addr == FWS_A_TAU)
      begin
         if (!bus.wdata[0])
            temp_unprotect_bit <= 1'b0;
         else if (bus.from_flash)
            temp_unprotect_bit <= 1'b1;
      end
   end

   // Non-volatile protection words; bits only go to zero
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         nv_access_protect_low <= FWS_V_ONES;
         nv_access_protect_high <= FWS_V_ONES;
         accp_reg <= 1'b0;
         prot_cnt_reg <= 5'h00;
      end
      else if (finish && op_reg == FWS_OP_PROT && target_address_low == FWS_PROT_ADDR)
      begin
         if (data0_low == FWS_PROT_CLR0 && prot_cnt_reg < FWS_PROT_MAX)
            nv_access_protect_low <= nv_access_protect_low & data0_low;
         if (data0_high == FWS_PROT_CLR0 && prot_cnt_reg < FWS_PROT_MAX)
         begin
            nv_access_protect_high <= nv_access_protect_high & data0_high;
            prot_cnt_reg <= prot_cnt_reg + 5'h01;
         end
      end
   end

   // Array outputs; double word aligned on even word
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         arr_addr <= 32'h0000_0000;
         arr_data <= 64'h0000_0000_0000_0000;
         arr_sectors <= 32'h0000_0000;
         arr_done <= 1'b0;
      end
      else
      begin
         arr_done <= finish;
         arr_addr <= {target_address_high, target_address_low};
         if (op_reg == FWS_OP_DWORD)
            arr_addr[FWS_B_ADDRESS_BIT_TWO] <= 1'b0;
         arr_data <= {data1_high, data1_low, data0_high, data0_low};
         arr_sectors <= {erase_sector_select_high, erase_sector_select_low};
      end
   end
   assign arr_busy = st_reg == FWS_RUN;
   assign arr_op = op_reg;

   // Read port, answer one cycle later
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         rdata_reg <= FWS_V_ZERO;
      else if (bus.rd)
      begin
         unique case (bus.addr)
            FWS_A_CW0L: rdata_reg <= control_word0_low;
            FWS_A_CW0H: rdata_reg <= control_word0_high;
            FWS_A_ES_L: rdata_reg <= erase_sector_select_low;
            FWS_A_ES_H: rdata_reg <= erase_sector_select_high;
            FWS_A_TA_L: rdata_reg <= target_address_low;
            FWS_A_TA_H: rdata_reg <= target_address_high;
            FWS_A_D0_L: rdata_reg <= data0_low;
            FWS_A_D0_H: rdata_reg <= data0_high;
            FWS_A_D1_L: rdata_reg <= data1_low;
            FWS_A_D1_H: rdata_reg <= data1_high;
            FWS_A_ERR: rdata_reg <= error_register;
            FWS_A_TAU: rdata_reg <= {15'h0000, temp_unprotect_bit};
            FWS_A_STAT: rdata_reg <= {11'h000, prot_cnt_reg};
            default: rdata_reg <= FWS_V_ZERO;
         endcase
      end
      else
         rdata_reg <= FWS_V_ZERO;
   end
   assign bus.rdata = rdata_reg;
endmodule : fws_dev
`default_nettype wire

/* File: testbench/fws_checker.sv */
// Assertions on the sequencer bus and array outputs
`timescale 1ns/100ps
`default_nettype none
module fws_checker
   import fws_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Internal bus
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] rdata,
   // Array and protection
   input wire logic arr_busy,
   input wire logic arr_done,
   input wire logic [2:0] arr_op,
   input wire logic [31:0] arr_addr,
   input wire logic [31:0] arr_sectors,
   input wire logic [15:0] nv_access_protect_low,
   input wire logic [15:0] nv_access_protect_high
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // Write to control word zero high, the only start path
   logic cw_wr;
   assign cw_wr = wr && addr == FWS_A_CW0H;
   a_rdata_idle: assert property (!rd |=> rdata == 16'h0000)
      else $error("read data outside its slot");
   a_one_strobe: assert property (wr |-> !rd)
      else $error("write and read strobes together");
   a_start_cause: assert property ($rose(arr_busy) |-> $past(cw_wr) && $past(wdata[15]))
      else $error("array started without a start write");
   a_dword_op: assert property ($rose(arr_busy) && $past(wdata) == 16'h9000
      |-> arr_op == FWS_OP_DWORD)
      else $error("double word start gave wrong operation");
   a_dword_align: assert property ($rose(arr_busy) && arr_op == FWS_OP_DWORD
      |-> ##1 !arr_addr[2])
      else $error("double word address not aligned");
   a_erase_sect: assert property ($rose(arr_busy) && arr_op == FWS_OP_ERASE
      |=> arr_sectors != 32'h00000000)
      else $error("erase with no sector");
   a_suspend_request_stop: assert property (arr_busy && arr_op == FWS_OP_ERASE && cw_wr
      && wdata == FWS_V_SUSPEND_REQUEST |=> !arr_busy)
      else $error("erase kept running after suspend");
   a_start_held: assert property (arr_busy && !arr_done && cw_wr && wdata[15]
      |=> arr_busy || arr_done)
      else $error("second start disturbed running operation");
   a_prot_low: assert property ($changed(nv_access_protect_low)
      |-> nv_access_protect_low == 16'hFFFE)
      else $error("protect low changed to wrong value");
   a_prot_high: assert property ($changed(nv_access_protect_high)
      |-> nv_access_protect_high == 16'hFFFE)
      else $error("protect high changed to wrong value");
endmodule : fws_checker
`default_nettype wire

/* File: testbench/test_fws.sv */
// Self-checking bench: host and device ends joined by the bus
`timescale 1ns/100ps
`default_nettype none
module test_fws
   import fws_pkg::*;
   ;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] sw_addr = 4'h0;
   logic [15:0] sw_wdata = 16'h0000;
   logic sw_wr = 1'b0;
   logic sw_rd = 1'b0;
   logic sw_from_flash = 1'b0;
   logic [15:0] sw_rdata;
   logic arr_busy, arr_done, access_protected;
   logic [2:0] arr_op;
   logic [31:0] arr_addr, arr_sectors;
   logic [63:0] arr_data;
   logic [15:0] nv_access_protect_low, nv_access_protect_high;
   int bad_count = 0;
   int check_count = 0;
   fws_if bus ();
   fws_host u_fws_host (.clk, .rst_b, .sw_addr, .sw_wdata, .sw_wr, .sw_rd,
      .sw_from_flash, .sw_rdata, .bus(bus));
   fws_dev u_fws_dev (.clk, .rst_b, .bus(bus), .arr_busy, .arr_done, .arr_op,
      .arr_addr, .arr_data, .arr_sectors, .access_protected,
      .nv_access_protect_low, .nv_access_protect_high);
   fws_checker u_fws_checker (.clk, .rst_b, .addr(bus.addr), .wdata(bus.wdata),
      .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata), .arr_busy, .arr_done, .arr_op,
      .arr_addr, .arr_sectors, .nv_access_protect_low, .nv_access_protect_high);
   always #2 clk = ~clk;
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wrap_up();
      $display("Checks %0d, errors %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   // Gap of one cycle between writes keeps each strobe a clean pulse
   // Address and data held together, one 16-bit word per write
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge clk);
      sw_wr <= 1'b0;
   endtask : wr
   // Data arrive two cycles after the strobe: one host stage, one device stage
   task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge clk);
      sw_rd <= 1'b0;
      @(posedge clk);
      #1 check(sw_rdata, exp);
   endtask : rd_chk
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask : settle
   task automatic wait_done(input int lim);
      int n;
      n = 0;
      while (arr_done !== 1'b1 && n < lim)
      begin
         @(posedge clk);
         #1 n++;
      end
      check(n < lim, 1'b1);
   endtask : wait_done
   initial
   begin
      #40000;
      bad_count++;
      wrap_up();
   end
   initial
   begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      // Word program, then a second start while it runs
      wr(FWS_A_CW0H, 16'h2000);
      wr(FWS_A_TA_L, 16'h5554);
      wr(FWS_A_TA_H, 16'h0002);
      wr(FWS_A_D0_L, 16'hAAAA);
      wr(FWS_A_D0_H, 16'hAAAA);
      wr(FWS_A_CW0H, 16'hA000);
      settle();
      check(arr_busy, 1'b1);
      check(arr_op, FWS_OP_WORD);
      check(arr_addr, 32'h00025554);
      check(arr_data[31:0], 32'hAAAAAAAA);
      wr(FWS_A_CW0H, 16'hA000);
      settle();
      check(arr_busy, 1'b1);
      wait_done(32);
      rd_chk(FWS_A_CW0H, FWS_V_ZERO);
      // Double word with address bit two set
      wr(FWS_A_CW0H, FWS_V_DOUBLE_WORD_PROGRAM_SELECT);
      wr(FWS_A_TA_L, 16'h555C);
      wr(FWS_A_TA_H, 16'h0003);
      wr(FWS_A_D0_L, 16'h55AA);
      wr(FWS_A_D0_H, 16'h55AA);
      wr(FWS_A_D1_L, 16'hAA55);
      wr(FWS_A_D1_H, 16'hAA55);
      wr(FWS_A_CW0H, FWS_V_DOUBLE_WORD_PROGRAM_SELECT | FWS_V_START);
      settle();
      check(arr_op, FWS_OP_DWORD);
      check(arr_addr, 32'h00035558);
      check(arr_data, 64'hAA55AA5555AA55AA);
      wait_done(32);
      // Cancelled selection, and start with suspend set
      wr(FWS_A_CW0H, 16'h2000);
      wr(FWS_A_CW0H, FWS_V_ZERO);
      wr(FWS_A_CW0H, FWS_V_START);
      settle();
      check(arr_busy, 1'b0);
      wr(FWS_A_CW0H, 16'h2000);
      wr(FWS_A_CW0H, 16'hE000);
      settle();
      check(arr_busy, 1'b0);
      wr(FWS_A_CW0H, FWS_V_ZERO);
      // Erase, suspend, program another sector, resume
      wr(FWS_A_CW0H, FWS_V_SER);
      wr(FWS_A_ES_L, 16'h0003);
      wr(FWS_A_ES_H, FWS_V_ZERO);
      wr(FWS_A_CW0H, FWS_V_SER | FWS_V_START);
      settle();
      check(arr_sectors, 32'h00000003);
      wr(FWS_A_CW0H, FWS_V_SUSPEND_REQUEST);
      settle();
      check(arr_busy, 1'b0);
      wr(FWS_A_CW0H, FWS_V_ZERO);
      wr(FWS_A_CW0H, 16'h2000);
      wr(FWS_A_TA_L, 16'h5554);
      wr(FWS_A_TA_H, 16'h0004);
      wr(FWS_A_D0_L, 16'hAAAA);
      wr(FWS_A_D0_H, 16'h5555);
      wr(FWS_A_CW0H, 16'hA000);
      settle();
      check(arr_op, FWS_OP_WORD);
      wr(FWS_A_CW0H, FWS_V_SUSPEND_REQUEST);
      settle();
      check(arr_busy, 1'b1);
      wait_done(32);
      rd_chk(FWS_A_ES_L, 16'h0003);
      wr(FWS_A_CW0H, FWS_V_SER);
      wr(FWS_A_CW0H, FWS_V_SER | FWS_V_START);
      settle();
      check(arr_op, FWS_OP_ERASE);
      wait_done(128);
      rd_chk(FWS_A_ES_L, FWS_V_ZERO);
      rd_chk(FWS_A_ES_H, FWS_V_ZERO);
      // Resume with another select bit aborts
      wr(FWS_A_CW0H, FWS_V_SER);
      wr(FWS_A_ES_L, 16'h0004);
      wr(FWS_A_CW0H, FWS_V_SER | FWS_V_START);
      wr(FWS_A_CW0H, FWS_V_SUSPEND_REQUEST);
      wr(FWS_A_CW0H, FWS_V_SPR | FWS_V_START);
      settle();
      check(arr_busy, 1'b0);
      rd_chk(FWS_A_ERR, 16'h0001);
      wr(FWS_A_ERR, FWS_V_ZERO);
      rd_chk(FWS_A_ERR, FWS_V_ZERO);
      // Temporary unprotect, permanent disable and re-enable
      wr(FWS_A_TAU, 16'h0001);
      rd_chk(FWS_A_TAU, FWS_V_ZERO);
      @(posedge clk);
      sw_from_flash <= 1'b1;
      wr(FWS_A_TAU, 16'h0001);
      rd_chk(FWS_A_TAU, 16'h0001);
      @(posedge clk);
      sw_from_flash <= 1'b0;
      wr(FWS_A_CW0H, FWS_V_SPR);
      wr(FWS_A_TA_L, FWS_PROT_ADDR);
      wr(FWS_A_TA_H, 16'h0008);
      wr(FWS_A_D0_L, FWS_PROT_CLR0);
      wr(FWS_A_CW0H, FWS_V_SPR | FWS_V_START);
      wait_done(40);
      settle();
      check(nv_access_protect_low, 16'hFFFE);
      check(nv_access_protect_high, 16'hFFFF);
      wr(FWS_A_CW0H, FWS_V_SPR);
      wr(FWS_A_D0_L, FWS_V_ONES);
      wr(FWS_A_D0_H, FWS_PROT_CLR0);
      wr(FWS_A_CW0H, FWS_V_SPR | FWS_V_START);
      wait_done(40);
      settle();
      check(nv_access_protect_high, 16'hFFFE);
      rd_chk(FWS_A_STAT, 16'h0001);
      wr(FWS_A_TAU, FWS_V_ZERO);
      rd_chk(FWS_A_TAU, FWS_V_ZERO);
      rd_chk(4'hD, FWS_V_ZERO);
      wrap_up();
   end
endmodule : test_fws
`default_nettype wire
